// >>> verilog/sdram_two_bank.sv
// Two-bank synchronous DRAM command, mode and data-mask logic
`timescale 1ns/1ns
module sdram_two_bank
  import sdram_pkg::*;
#(
  parameter int DEPTH_WORDS = 1024,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Command pins
  input wire sdram_pkg::cmd_pins_t cmd_pins,
  input wire logic clock_gate,
  input wire sdram_pkg::mask_t masks,
  // Data lines, split into in/out/enable
  input wire logic [sdram_pkg::DATA_W-1:0] data_lines_in,
  output logic [sdram_pkg::DATA_W-1:0] data_lines_out,
  output logic [sdram_pkg::DATA_W-1:0] data_lines_oe,
  // Status
  output logic [sdram_pkg::MODE_W-1:0] mode_config,
  output logic [1:0] bank_open
);
  import sdram_pkg::*;
  localparam int MW = $clog2(DEPTH_WORDS);
  localparam int LAT_MAX = 3;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_s1_q, rst_n_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [2:0] burst_len(input logic [2:0] code);
    case (code)
      BL_1: burst_len = 3'h0;
      BL_2: burst_len = 3'h1;
      BL_4: burst_len = 3'h3;
      default: burst_len = 3'h7;
    endcase
  endfunction
  // Address of beat n from start column, sequential wraps or interleaves within the burst
  function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] start, input logic [7:0] n,
      input logic [2:0] mask, input logic il, input logic page);
    logic [COL_W-1:0] lo;
    lo = il ? ((start & COL_W'(mask)) ^ COL_W'(n)) : ((start + COL_W'(n)) & COL_W'(mask));
    if (page) beat_col = start + COL_W'(n);
    else beat_col = (start & ~COL_W'(mask)) | lo;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Sampling and decode
  logic gate_q;
  wire run = gate_q;
  wire sel = run && !cmd_pins.select_n;
  wire cmd_t cmd = sel ? cmd_t'({cmd_pins.row_strobe_n, cmd_pins.col_strobe_n, cmd_pins.write_n}) : CMD_NOP;
  wire bank = cmd_pins.addr[BANK_BIT];
  wire ap = cmd_pins.addr[AP_BIT];
  wire [COL_W-1:0] col_in = cmd_pins.addr[COL_W-1:0];
  wire [ROW_W-1:0] row_in = cmd_pins.addr[ROW_W-1:0];
  wire [2:0] bl_code = mode_config[BL_LSB +: 3];
  wire order_il = mode_config[ORDER_BIT];
  wire [2:0] lat = mode_config[LAT_LSB +: 3];
  wire single_wr = mode_config[WMODE_LSB +: 2] == WM_SINGLE;
  wire page_mode = bl_code == BL_PAGE;
  wire [2:0] blen = burst_len(bl_code);
  // Clock gate sampled this edge suspends the next one
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) gate_q <= 1'b1;
    else gate_q <= clock_gate;
  end

  ////////////////////////////////////////////////////////////////////////
  // Burst engine; a new column command restarts it on any cycle
  logic [ROW_W-1:0] row_q [2];
  logic bst_act_q, bst_wr_q, bst_bank_q, bst_ap_q;
  logic [COL_W-1:0] bst_col_q;
  logic [7:0] bst_n_q;
  wire col_cmd = cmd == CMD_READ || cmd == CMD_WRITE;
  wire stop_cmd = cmd == CMD_STOP && page_mode;
  wire pre_hit = cmd == CMD_PRECHARGE && (ap || bank == bst_bank_q);
  wire [7:0] last_n = page_mode ? 8'hff : ((bst_wr_q && single_wr) ? 8'h00 : {5'h0, blen});
  wire beat = run && (bst_act_q || col_cmd);
  wire cur_wr = col_cmd ? (cmd == CMD_WRITE) : bst_wr_q;
  wire cur_bank = col_cmd ? bank : bst_bank_q;
  wire [7:0] cur_n = col_cmd ? 8'h00 : bst_n_q;
  wire [COL_W-1:0] cur_start = col_cmd ? col_in : bst_col_q;
  wire [COL_W-1:0] cur_col = beat_col(cur_start, cur_n, blen, order_il, page_mode);
  wire cur_last = col_cmd ? (page_mode ? 1'b0 : (cmd == CMD_WRITE && single_wr) || blen == 3'h0)
                          : (bst_n_q == last_n);
  wire ap_due = bst_act_q && run && bst_ap_q && bst_n_q == last_n && !col_cmd;
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bst_act_q <= 1'b0;
      bst_wr_q <= 1'b0;
      bst_bank_q <= 1'b0;
      bst_ap_q <= 1'b0;
      bst_col_q <= '0;
      bst_n_q <= '0;
    end else if (run) begin
      if (col_cmd) begin
        bst_act_q <= !cur_last;
        bst_wr_q <= cmd == CMD_WRITE;
        bst_bank_q <= bank;
        bst_ap_q <= ap;
        bst_col_q <= col_in;
        bst_n_q <= 8'h01;
      end else if (stop_cmd || pre_hit || (bst_act_q && cur_last)) begin
        bst_act_q <= 1'b0;
      end else if (bst_act_q) begin
        bst_n_q <= bst_n_q + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode register and bank rows; auto precharge closes the bank after the last beat of bursts longer than one beat
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mode_config <= MODE_RESET;
      bank_open <= 2'b00;
      row_q[0] <= '0;
      row_q[1] <= '0;
    end else begin
      if (cmd == CMD_MODE) mode_config <= cmd_pins.addr;
      if (cmd == CMD_ACTIVATE) begin
        bank_open[bank] <= 1'b1;
        row_q[bank] <= row_in;
      end
      if (cmd == CMD_PRECHARGE) begin
        if (ap) bank_open <= 2'b00;
        else bank_open[bank] <= 1'b0;
      end
      if (ap_due) bank_open[bst_bank_q] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Storage array, byte lanes written independently
  logic [DATA_W-1:0] mem [2*DEPTH_WORDS];
  wire [MW:0] cur_addr = {cur_bank, MW'({row_q[cur_bank], cur_col})};
  // Data given with a page-mode stop command itself still lands; only later beats are ignored
  wire wr_beat = beat && cur_wr;
  wire rd_beat = beat && !cur_wr && !stop_cmd && !pre_hit;
  always_ff @(posedge clk_sys) begin
    if (wr_beat && !masks.low_byte_mask) mem[cur_addr][7:0] <= data_lines_in[7:0];
    if (wr_beat && !masks.high_byte_mask) mem[cur_addr][15:8] <= data_lines_in[15:8];
  end

  ////////////////////////////////////////////////////////////////////////
  // Read pipeline: latency stages (pipe_q[0] to pipe_q[latency-1]) feed the output FIFO-backed stage
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } rd_stage_t;
  rd_stage_t pipe_q [LAT_MAX];
  logic [1:0] mask_dly_q [MASK_TO_FLOAT_DELAY];
  wire [1:0] lat_sel = lat[1:0] - 2'd1;
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < LAT_MAX; i++) pipe_q[i] <= '0;
      for (int i = 0; i < MASK_TO_FLOAT_DELAY; i++) mask_dly_q[i] <= 2'b00;
    end else if (run) begin
      pipe_q[0] <= '{valid: rd_beat, data: mem[cur_addr]};
      for (int i = 1; i < LAT_MAX; i++) pipe_q[i] <= pipe_q[i-1];
      // Precharge cancels beats still in flight older than the cut point
      if (pre_hit) for (int i = 0; i < LAT_MAX; i++) pipe_q[i].valid <= 1'b0;
      mask_dly_q[0] <= {masks.high_byte_mask, masks.low_byte_mask};
      mask_dly_q[1] <= mask_dly_q[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output FIFO: absorbs beats so the pad stage may stall on clock suspend
  logic fifo_valid;
  logic fifo_in_ready;
  logic [DATA_W-1:0] fifo_data;
  wire rd_out = pipe_q[lat_sel].valid && run;
  sdram_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .in_valid(rd_out && fifo_in_ready),
    .in_ready(fifo_in_ready),
    .in_data(pipe_q[lat_sel].data),
    .out_valid(fifo_valid),
    .out_ready(run),
    .out_data(fifo_data),
    .flush(pre_hit)
  );
  // Pad stage: drive only while a read beat is presented, lanes float under mask
  logic [DATA_W-1:0] dq_q;
  logic [1:0] drv_q;
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dq_q <= '0;
      drv_q <= 2'b00;
    end else if (run) begin
      dq_q <= fifo_data;
      drv_q <= fifo_valid ? ~mask_dly_q[1] : 2'b00;
    end
  end
  assign data_lines_out = dq_q;
  assign data_lines_oe = {{8{drv_q[1]}}, {8{drv_q[0]}}};
endmodule // sdram_two_bank

// >>> verilog/sdram_pkg.sv
// Package: command encodings, mode field layout, timing counts and pin bundles for the two-bank DRAM model
package sdram_pkg;
  // Geometry
  localparam int ROW_W = 9;
  localparam int COL_W = 8;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 10;
  localparam int MODE_W = 10;
  // Mode field positions and command address bits
  localparam int BL_LSB = 0;
  localparam int ORDER_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int RSVD_BIT = 7;
  localparam int WMODE_LSB = 8;
  localparam int BANK_BIT = 9;
  localparam int AP_BIT = 8;
  localparam logic [MODE_W-1:0] MODE_RESET = 10'h021;
  // Burst length and write mode codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [1:0] WM_BURST = 2'h0;
  localparam logic [1:0] WM_SINGLE = 2'h2;
  // Cycle figures
  localparam int MASK_TO_FLOAT_DELAY = 2;
  localparam int STOP_WRITE_IGNORE = 1;
  localparam int COLUMN_TO_COLUMN_GAP = 1;
  // Commands decoded from {row, column, write} strobes (active low)
  typedef enum logic [2:0] {
    CMD_MODE = 3'b000,
    CMD_REFRESH = 3'b001,
    CMD_PRECHARGE = 3'b010,
    CMD_ACTIVATE = 3'b011,
    CMD_WRITE = 3'b100,
    CMD_READ = 3'b101,
    CMD_STOP = 3'b110,
    CMD_NOP = 3'b111
  } cmd_t;
  // Command pins as sampled
  typedef struct packed {
    logic select_n;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_n;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;
  // Byte masks
  typedef struct packed {
    logic high_byte_mask;
    logic low_byte_mask;
  } mask_t;
endpackage

// >>> verilog/sdram_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module sdram_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Flush
  input wire logic flush
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, rd_q;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  // Honest full and empty from extended pointers
  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  // Pointers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (do_wr) wr_q <= wr_q + 1'b1;
      if (do_rd) rd_q <= rd_q + 1'b1;
    end
  end
  // Storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (do_wr) mem[wr_q[AW-1:0]] <= in_data;
  end
endmodule // sdram_fifo

// >>> tb/sdram_two_bank_chk.sv
// Assertion checker for the two-bank DRAM block, bound to its ports
`timescale 1ns/1ns
module sdram_two_bank_chk
  import sdram_pkg::*;
#(
  parameter int DEPTH_WORDS = 1024,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Pins watched
  input wire sdram_pkg::cmd_pins_t cmd_pins,
  input wire logic clock_gate,
  input wire sdram_pkg::mask_t masks,
  input wire logic [sdram_pkg::DATA_W-1:0] data_lines_in,
  input wire logic [sdram_pkg::DATA_W-1:0] data_lines_out,
  input wire logic [sdram_pkg::DATA_W-1:0] data_lines_oe,
  input wire logic [sdram_pkg::MODE_W-1:0] mode_config,
  input wire logic [1:0] bank_open
);
  logic gate_q;
  cmd_t cmd;
  logic take;
  ////////////////////////////////////////
  // A command counts only if the clock ran in the cycle before
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= clock_gate;
    end
  end
  assign cmd = cmd_t'({cmd_pins.row_strobe_n, cmd_pins.col_strobe_n, cmd_pins.write_n});
  assign take = gate_q && !cmd_pins.select_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // Command effects, suspension and lane masking
  a_mode_write: assert property (take && cmd == CMD_MODE |=> mode_config == $past(cmd_pins.addr))
    else $error("mode register not loaded");
  a_deselect_hold: assert property (cmd_pins.select_n |=> $stable(mode_config))
    else $error("mode changed while deselected");
  a_gate_freeze: assert property (!clock_gate |=> ##1 $stable(data_lines_oe) && $stable(mode_config))
    else $error("state moved in a suspended cycle");
  a_row_open: assert property (take && cmd == CMD_ACTIVATE |=> bank_open[$past(cmd_pins.addr[BANK_BIT])])
    else $error("activated bank not open");
  a_close_all: assert property (take && cmd == CMD_PRECHARGE && cmd_pins.addr[AP_BIT] |=> bank_open == 2'b00)
    else $error("banks open after precharge all");
  a_lane_low: assert property (gate_q && masks.low_byte_mask && clock_gate ##1 clock_gate[*2] |=> data_lines_oe[7:0] == 8'h00)
    else $error("masked low lane still driven");
  a_lane_split: assert property (data_lines_oe[7:0] == {8{data_lines_oe[0]}} && data_lines_oe[15:8] == {8{data_lines_oe[8]}})
    else $error("drive enable not per byte lane");
  a_pre_float: assert property (take && cmd == CMD_PRECHARGE && cmd_pins.addr[AP_BIT] ##1 (cmd != CMD_READ && clock_gate)[*6] |=> data_lines_oe == 16'h0000)
    else $error("data driven after precharge");
  c_read: cover property (take && cmd == CMD_READ);
  c_write_masked: cover property (take && cmd == CMD_WRITE && masks.high_byte_mask);
  c_suspend: cover property (!clock_gate ##1 clock_gate);
endmodule // sdram_two_bank_chk
bind sdram_two_bank sdram_two_bank_chk #(.DEPTH_WORDS(DEPTH_WORDS), .FIFO_DEPTH(FIFO_DEPTH)) i_chk (.clk_sys(clk_sys),
  .rstn(rstn), .cmd_pins(cmd_pins), .clock_gate(clock_gate), .masks(masks), .data_lines_in(data_lines_in),
  .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .mode_config(mode_config), .bank_open(bank_open));

// >>> tb/sdram_ctrl_model.sv
// Memory controller model driving command, mask and write-data pins
`timescale 1ns/1ns
module sdram_ctrl_model
  import sdram_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Command side
  output sdram_pkg::cmd_pins_t cmd_pins,
  output logic clock_gate,
  output sdram_pkg::mask_t masks,
  // Write data
  output logic [sdram_pkg::DATA_W-1:0] wr_data,
  output logic wr_oe
);
  ////////////////////////////////////////
  // Deselected and idle until the bench starts
  initial begin
    cmd_pins = {1'b1, CMD_NOP, 10'h000};
    clock_gate = 1'b1;
    masks = 2'b00;
    wr_data = 16'h0000;
    wr_oe = 1'b0;
  end
  // One command a cycle; released data lines toggle so a stale value never looks valid
  task automatic step(input cmd_t c, input logic [9:0] a = 10'h000, input mask_t m = 2'b00,
                      input logic s = 1'b0, input logic g = 1'b1, input logic [15:0] d = 16'h0000);
    @(posedge clk_sys);
    #1;
    cmd_pins = {s, c, a};
    masks = m;
    clock_gate = g;
    wr_oe = (c == CMD_WRITE);
    wr_data = (c == CMD_WRITE) ? d : ~wr_data;
  endtask
  task automatic nop(input int k);
    repeat (k) step(CMD_NOP);
  endtask
  // Precharge all, then load the mode with the reserved bit forced low
  task automatic mode_set(input logic [9:0] m);
    step(CMD_PRECHARGE, 10'h100);
    nop(2);
    step(CMD_MODE, {m[9:8], 1'b0, m[6:0]});
    nop(3);
  endtask
  task automatic open_row();
    step(CMD_ACTIVATE, 10'h205);
    nop(3);
  endtask
  // Pause and refreshes satisfy both power-on options; the run is far shorter than one refresh period
  task automatic powerup(input logic [9:0] m);
    nop(20000);
    step(CMD_PRECHARGE, 10'h100);
    nop(2);
    repeat (8) begin
      step(CMD_REFRESH);
      nop(8);
    end
    mode_set(m);
    repeat (2) begin
      step(CMD_REFRESH);
      nop(8);
    end
  endtask
endmodule // sdram_ctrl_model

// >>> tb/test_sdram_two_bank.sv
// Self-checking bench for the two-bank DRAM block
`timescale 1ns/1ns
module test_sdram_two_bank;
  import sdram_pkg::*;
  logic clk_sys;
  logic rstn;
  cmd_pins_t cmd_pins;
  logic clock_gate;
  mask_t masks;
  logic [15:0] data_lines_in, data_lines_out, data_lines_oe, wr_data, d, oe;
  logic [9:0] mode_config, m;
  logic [1:0] bank_open;
  logic wr_oe;
  int fails = 0, compares = 0, t, n, t1;
  ////////////////////////////////////////
  sdram_two_bank #(.DEPTH_WORDS(1024), .FIFO_DEPTH(8)) i_dut (.clk_sys(clk_sys), .rstn(rstn), .cmd_pins(cmd_pins),
    .clock_gate(clock_gate), .masks(masks), .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .mode_config(mode_config), .bank_open(bank_open));
  sdram_ctrl_model i_ctrl (.clk_sys(clk_sys), .cmd_pins(cmd_pins), .clock_gate(clock_gate), .masks(masks),
    .wr_data(wr_data), .wr_oe(wr_oe));
  // Shared lines: controller write data wins while wr_oe is set, else the device where it drives, else the controller's value
  assign data_lines_in = wr_oe ? wr_data : ((data_lines_oe & data_lines_out) | (~data_lines_oe & wr_data));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  // Compare, report and read helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Read bank B column 3: cycles to first beat, beat count, first word and its enables
  task automatic rd(input mask_t k, output int tt, output int nn, output logic [15:0] dd, output logic [15:0] ee);
    tt = 0;
    nn = 0;
    i_ctrl.step(CMD_READ, 10'h203, k);
    while (data_lines_oe === 16'h0000 && tt < 12) begin
      i_ctrl.step(CMD_NOP, 10'h000, k);
      tt++;
    end
    dd = data_lines_out;
    ee = data_lines_oe;
    while (data_lines_oe !== 16'h0000 && nn < 12) begin
      i_ctrl.step(CMD_NOP, 10'h000, k);
      nn++;
    end
    if (tt == 12 || nn == 12) begin
      fails++;
      end_of_test();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    i_ctrl.nop(3);
    chk({6'h00, mode_config}, 16'h0021);
    chk(data_lines_oe, 16'h0000);
    i_ctrl.powerup(10'h020);
    i_ctrl.open_row();
    chk({14'h0000, bank_open}, 16'h0002);
    i_ctrl.step(CMD_WRITE, 10'h203, 2'b00, 1'b0, 1'b1, 16'h1234);
    i_ctrl.step(CMD_WRITE, 10'h203, 2'b10, 1'b0, 1'b1, 16'hA5C3);
    // Each latency with its own burst length
    for (int i = 1; i <= 3; i++) begin
      m = {WM_BURST, 1'b0, i[2:0], 1'b0, (i == 1) ? BL_1 : ((i == 2) ? BL_2 : BL_4)};
      i_ctrl.mode_set(m);
      chk({6'h00, mode_config}, {6'h00, m});
      i_ctrl.open_row();
      rd(2'b00, t, n, d, oe);
      if (i == 1) t1 = t;
      chk(d, 16'h12C3);
      chk_n(t - t1, i - 1);
      chk_n(n, 1 << (i - 1));
    end
    rd(2'b01, t, n, d, oe);
    chk(oe, 16'hFF00);
    chk({8'h00, d[15:8]}, 16'h0012);
    i_ctrl.step(CMD_READ, 10'h203);
    i_ctrl.step(CMD_PRECHARGE, 10'h100);
    i_ctrl.nop(8);
    chk(data_lines_oe, 16'h0000);
    i_ctrl.step(CMD_MODE, 10'h011, 2'b00, 1'b1);
    i_ctrl.step(CMD_NOP, 10'h000, 2'b00, 1'b0, 1'b0);
    i_ctrl.step(CMD_MODE, 10'h011);
    i_ctrl.nop(2);
    chk({6'h00, mode_config}, {6'h00, m});
    end_of_test();
  end
endmodule // test_sdram_two_bank
